/* File: dv/cpu_core_model.sv */
/*
 CPU core model: issues one data-space access at a time and reports the answer.
 Assumes the access port contract of the memory block, driven on the core clock.
*/
`timescale 1ns/1ns
module cpu_core_model (
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic wait_i,
    input wire logic valid_i,
    input wire logic [7:0] rdata_i,
    output logic req_o = 1'b0,
    output dmem_pkg::acc_kind_e kind_o = dmem_pkg::ACC_LOAD,
    output dmem_pkg::addr_mode_e mode_o = dmem_pkg::AM_DIRECT,
    output dmem_pkg::ptr_sel_e ptr_o = dmem_pkg::PTR_X,
    output logic [15:0] addr_o = 16'h0000,
    output logic [7:0] wdata_o = 8'h00
);
    // Low address bits double as displacement and short IO address
    task automatic acc(input dmem_pkg::acc_kind_e k, input dmem_pkg::addr_mode_e m,
        input dmem_pkg::ptr_sel_e p, input logic [15:0] a, input logic [7:0] w,
        input int gap, output logic [7:0] rd, output int lat, output int st);
        rd = 8'hxx;
        lat = 0;
        st = 0;
        repeat (gap) @(posedge clk_i);
        req_o <= 1'b1;
        kind_o <= k;
        mode_o <= m;
        ptr_o <= p;
        addr_o <= a;
        wdata_o <= w;
        do @(posedge clk_i); while (ready_i !== 1'b1);
        // Released lines show no stale value
        req_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~w;
        do
        begin
            @(posedge clk_i);
            lat++;
            if (wait_i === 1'b1) st++;
            if (valid_i === 1'b1) rd = rdata_i;
        end
        while (ready_i !== 1'b1 && lat < 40);
    endtask
endmodule // cpu_core_model

/* File: dv/data_memory_eeprom_access_tb.sv */
/*
 Self-checking testbench for the data-memory and EEPROM access block.
 Assumes shortened EEPROM write times and the CPU core model on the access port.
*/
`timescale 1ns/1ns
module data_memory_eeprom_access_tb;
    localparam int EW = 20;
    localparam int SO = 10;
    logic clk = 1'b0, nrst = 1'b0, pwr_nrst = 1'b0, prog_we = 1'b0;
    logic [15:0] pc = 16'h0000, paddr = 16'h0000, pdata = 16'h0000, addr, instr;
    logic req, rdy, cwait, valid, iowe, iore, busy, boot, refused;
    logic [7:0] rdata, ioaddr, iowd, wdata, rd, io_seen, iowd_seen, iore_seen;
    dmem_pkg::acc_kind_e kind;
    dmem_pkg::addr_mode_e mode;
    dmem_pkg::ptr_sel_e ptr;
    int lat, st, busy_len = 0, last_len = 0, cyc = 0, error_cnt = 0, checked = 0;
    logic [7:0] ed [4] = '{8'h00, 8'h0f, 8'h00, 8'h5a};
    logic [7:0] er [4] = '{8'hff, 8'h0f, 8'h0f, 8'h5a};

    data_memory_eeprom_access #(.ERASE_WRITE_CYC(EW), .SINGLE_OP_CYC(SO))
        data_memory_eeprom_access_i (.core_clk_i(clk), .nrst_i(nrst),
        .pwr_on_nrst_i(pwr_nrst), .clk_en_i(1'b1), .req_i(req), .req_kind_i(kind),
        .addr_mode_i(mode), .ptr_sel_i(ptr), .disp_i(addr[5:0]), .addr_i(addr),
        .io_addr_i(addr[5:0]), .wdata_i(wdata), .ready_o(rdy), .cpu_wait_o(cwait),
        .rdata_o(rdata), .rdata_valid_o(valid), .io_addr_o(ioaddr), .io_wdata_o(iowd),
        .io_we_o(iowe), .io_re_o(iore), .io_rdata_i(ioaddr ^ 8'h5a), .ee_busy_o(busy),
        .pc_i(pc), .instr_o(instr), .boot_section_o(boot), .prog_we_i(prog_we),
        .prog_waddr_i(paddr), .prog_wdata_i(pdata), .prog_refused_o(refused));
    cpu_core_model cpu_core_model_i (.clk_i(clk), .ready_i(rdy), .wait_i(cwait),
        .valid_i(valid), .rdata_i(rdata), .req_o(req), .kind_o(kind), .mode_o(mode),
        .ptr_o(ptr), .addr_o(addr), .wdata_o(wdata));

    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
        if (busy !== 1'b1 && busy_len != 0) last_len <= busy_len;
        if (iowe === 1'b1) io_seen <= ioaddr;
        if (iowe === 1'b1) iowd_seen <= iowd;
        if (iore === 1'b1) iore_seen <= ioaddr;
        if (cyc == 6000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic a(input dmem_pkg::acc_kind_e k, input dmem_pkg::addr_mode_e m,
        input dmem_pkg::ptr_sel_e p, input logic [15:0] ad, input logic [7:0] w, input int g);
        cpu_core_model_i.acc(k, m, p, ad, w, g, rd, lat, st);
    endtask
    task automatic sd(input logic [15:0] ad, input logic [7:0] w);
        a(dmem_pkg::ACC_STORE, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, ad, w, 0);
    endtask
    task automatic ld(input logic [15:0] ad);
        a(dmem_pkg::ACC_LOAD, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, ad, 8'h00, 0);
    endtask
    task automatic drain();
        for (int n = 0; n < 500 && busy === 1'b1; n++) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic ee_wr(input logic [10:0] ad, input logic [7:0] d, input logic [1:0] op,
        input int late);
        sd(16'h0041, ad[7:0]);
        sd(16'h0042, {5'h00, ad[10:8]});
        sd(16'h0040, d);
        sd(16'h003f, {2'h0, op, 4'h4});
        a(dmem_pkg::ACC_STORE, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, 16'h003f,
            {2'h0, op, 4'h2}, late);
    endtask
    task automatic ee_rd(input logic [10:0] ad);
        sd(16'h0041, ad[7:0]);
        sd(16'h0042, {5'h00, ad[10:8]});
        sd(16'h003f, 8'h01);
        chk(16'(st), 16'h0004);
        a(dmem_pkg::ACC_IO_IN, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, 16'h0020, 8'h00, 0);
    endtask

    task automatic t_sram();
        sd(16'h0100, 8'ha5);
        sd(16'h10ff, 8'h3c);
        ld(16'h0100);
        chk(rd, 8'ha5);
        chk(16'(lat), 16'h0002);
        ld(16'h10ff);
        chk(rd, 8'h3c);
        ld(16'h1100);
        chk(rd, 8'h00);
    endtask
    task automatic t_ptr();
        sd(16'h001a, 8'hff);
        sd(16'h001b, 8'h01);
        a(dmem_pkg::ACC_STORE, dmem_pkg::AM_POSTINC, dmem_pkg::PTR_X, 16'h0000, 8'h11, 3);
        ld(16'h001a);
        chk(rd, 8'h00);
        ld(16'h001b);
        chk(rd, 8'h02);
        a(dmem_pkg::ACC_LOAD, dmem_pkg::AM_PREDEC, dmem_pkg::PTR_X, 16'h0000, 8'h00, 0);
        chk(rd, 8'h11);
        sd(16'h013f, 8'h77);
        for (int i = 0; i < 2; i++)
        begin
            sd(16'h001c + 16'(2 * i), 8'h00);
            sd(16'h001d + 16'(2 * i), 8'h01);
            a(dmem_pkg::ACC_LOAD, dmem_pkg::AM_DISP, dmem_pkg::ptr_sel_e'(i + 1),
                16'h003f, 8'h00, 0);
            chk(rd, 8'h77);
        end
    endtask
    task automatic t_io();
        a(dmem_pkg::ACC_IO_OUT, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, 16'h0005, 8'h9c, 0);
        chk(io_seen, 8'h25);
        chk(iowd_seen, 8'h9c);
        sd(16'h0060, 8'h41);
        chk(io_seen, 8'h60);
        a(dmem_pkg::ACC_IO_IN, dmem_pkg::AM_DIRECT, dmem_pkg::PTR_X, 16'h0007, 8'h00, 0);
        chk(rd, 8'h7d);
        chk(iore_seen, 8'h27);
        ld(16'h00ff);
        chk(rd, 8'ha5);
        chk(iore_seen, 8'hff);
    endtask
    task automatic t_ee();
        ee_wr(11'h7ff, 8'h00, 2'h0, 6);
        chk(busy, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            ee_wr(11'h7ff, ed[i], 2'(i + 1), 0);
            chk(busy, 1'(i != 2));
            if (i != 2) chk(16'(st), 16'h0002);
            ld(16'h003f);
            chk(16'(rd[1]), 16'(i != 2));
            drain();
            chk(16'(last_len), 16'((i == 3) ? EW : SO));
            ee_rd(11'h7ff);
            chk(rd, er[i]);
        end
    endtask
    task automatic t_rst();
        ee_wr(11'h005, 8'h33, 2'h0, 0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(busy, 1'b1);
        drain();
        ee_rd(11'h005);
        chk(rd, 8'h33);
    endtask
    task automatic t_prog();
        prog_we <= 1'b1;
        paddr <= 16'h0010;
        pdata <= 16'h1234;
        pc <= 16'h0010;
        repeat (3) @(posedge clk);
        chk(instr, 16'h1234);
        paddr <= 16'hf001;
        @(posedge clk);
        prog_we <= 1'b0;
        pc <= 16'hf000;
        @(posedge clk);
        chk(refused, 1'b1);
        @(posedge clk);
        chk(boot, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        pwr_nrst <= 1'b1;
        @(posedge clk);
        t_sram();
        t_ptr();
        t_io();
        t_ee();
        t_rst();
        t_prog();
        report_and_stop();
    end
endmodule // data_memory_eeprom_access_tb

/* File: hw/data_memory_eeprom_access.sv */
/*
 Data-space decode, pointer addressing, SRAM, EEPROM access with CPU stall, program memory.
 Assumes a CPU core on the same clock that holds its request until ready_o and
 a power-on reset that is separate from the system reset.
*/
// Behaviour
// - Decode registers, standard IO, extended IO, SRAM.
// - Extended IO only via load and store.
// - Displacement adds unsigned offset to Y/Z.
// - Pre-decrement before, post-increment after access.
// - R26 to R31 form X, Y, Z.
// - Direct addressing reaches the whole data space.
// - SRAM access completes in two cycles.
// - EEPROM read stalls the CPU four cycles.
// - EEPROM write start stalls two cycles.
// - EEPROM is a separate byte space.
// - Self-timed write with pollable busy indication.
// - Write accepted only after guarded start sequence.
// - Write in progress survives system reset.
// - EEPROM registers sit in IO space.
// - Program memory of 16-bit words.
// - Program memory split into boot and application.
// - Strobe counts only within four cycles of arm.
// - Strobe clears when write time elapses.
// - Operation select picks erase/write and duration.
// - IO address plus 0x20 in data space.
`timescale 1ns/1ns
module data_memory_eeprom_access #(
    parameter int unsigned ERASE_WRITE_CYC = dmem_pkg::ERASE_WRITE_CYC,
    parameter int unsigned SINGLE_OP_CYC = dmem_pkg::SINGLE_OP_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic pwr_on_nrst_i,
    input wire logic clk_en_i,
    input wire logic req_i,
    input wire dmem_pkg::acc_kind_e req_kind_i,
    input wire dmem_pkg::addr_mode_e addr_mode_i,
    input wire dmem_pkg::ptr_sel_e ptr_sel_i,
    input wire logic [5:0] disp_i,
    input wire logic [15:0] addr_i,
    input wire logic [5:0] io_addr_i,
    input wire logic [7:0] wdata_i,
    output logic ready_o,
    output logic cpu_wait_o,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic [7:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic io_we_o,
    output logic io_re_o,
    input wire logic [7:0] io_rdata_i,
    output logic ee_busy_o,
    input wire logic [15:0] pc_i,
    output logic [15:0] instr_o,
    output logic boot_section_o,
    input wire logic prog_we_i,
    input wire logic [15:0] prog_waddr_i,
    input wire logic [15:0] prog_wdata_i,
    output logic prog_refused_o
);
    typedef struct packed {
        dmem_pkg::acc_state_e state;
        dmem_pkg::acc_kind_e kind;
        dmem_pkg::ptr_sel_e sel;
        logic [15:0] eff_addr;
        logic [7:0] wdata;
        logic [2:0] stall_cnt;
        logic [2:0] arm_cnt;
        logic [11:0] ee_addr;
        logic [7:0] ee_data;
        logic [7:0] rdata;
        logic rdata_valid;
        logic [15:0] instr;
        logic boot;
        logic prog_refused;
    } acc_s;

    typedef struct packed {
        logic busy;
        dmem_pkg::ee_op_e op;
        logic [dmem_pkg::TIMER_W-1:0] timer;
        logic [10:0] addr;
        logic [7:0] data;
    } pst_s;

    localparam acc_s ACC_RST = '{state: dmem_pkg::ST_IDLE, kind: dmem_pkg::ACC_LOAD,
        sel: dmem_pkg::PTR_X, default: '0};
    localparam pst_s PST_RST = '{op: dmem_pkg::OP_ERASE_WRITE, default: '0};

    logic [7:0] gpr [0:31];
    logic [7:0] sram [0:dmem_pkg::SRAM_WORDS-1];
    logic [7:0] eeprom [0:dmem_pkg::EE_WORDS-1];
    logic [15:0] flash [0:dmem_pkg::FLASH_WORDS-1];

    acc_s st_r;
    acc_s st_nxt;
    pst_s pst_r;
    pst_s pst_nxt;

    logic [4:0] base_lo;
    logic [15:0] base_ptr;
    logic [4:0] lat_lo;
    logic [15:0] lat_ptr;
    logic ptr_we;
    logic [15:0] ptr_new;
    logic is_wr;
    logic in_io;
    logic is_ee_reg;
    logic gpr_we;
    logic sram_we;
    logic [11:0] sram_idx;
    logic [7:0] read_val;
    logic ctrl_wr;
    logic rd_start;
    logic wr_start;
    logic ee_commit;
    logic [7:0] ee_val;
    logic prog_ok;
    logic pc_boot;
    dmem_pkg::ee_op_e wr_op;

    // Pointer pairs live in R26..R31
    always_comb
    begin
        unique case (ptr_sel_i)
            dmem_pkg::PTR_Y: base_lo = dmem_pkg::Y_LO_REG;
            dmem_pkg::PTR_Z: base_lo = dmem_pkg::Z_LO_REG;
            default: base_lo = dmem_pkg::X_LO_REG;
        endcase
        unique case (st_r.sel)
            dmem_pkg::PTR_Y: lat_lo = dmem_pkg::Y_LO_REG;
            dmem_pkg::PTR_Z: lat_lo = dmem_pkg::Z_LO_REG;
            default: lat_lo = dmem_pkg::X_LO_REG;
        endcase
    end
    assign base_ptr = {gpr[base_lo + 5'h1], gpr[base_lo]};
    assign lat_ptr = {gpr[lat_lo + 5'h1], gpr[lat_lo]};

    assign is_wr = (st_r.kind == dmem_pkg::ACC_STORE) || (st_r.kind == dmem_pkg::ACC_IO_OUT);
    assign in_io = (st_r.eff_addr >= dmem_pkg::STD_IO_BASE) && (st_r.eff_addr < dmem_pkg::SRAM_BASE);
    assign is_ee_reg = (st_r.eff_addr >= dmem_pkg::EE_CTRL_ADDR) &&
        (st_r.eff_addr <= dmem_pkg::EE_ADDRH_ADDR);
    assign sram_idx = st_r.eff_addr[11:0] - dmem_pkg::SRAM_BASE[11:0];
    assign gpr_we = (st_r.state == dmem_pkg::ST_EXEC) && is_wr &&
        (st_r.eff_addr < dmem_pkg::STD_IO_BASE);
    assign sram_we = (st_r.state == dmem_pkg::ST_EXEC) && is_wr &&
        (st_r.eff_addr >= dmem_pkg::SRAM_BASE) && (st_r.eff_addr < dmem_pkg::SRAM_END);
    assign wr_op = dmem_pkg::ee_op_e'(st_r.wdata[dmem_pkg::CTL_OPSEL_LSB +: 2]);

    // Data-space read decode
    always_comb
    begin
        read_val = 8'h00;
        if (st_r.eff_addr < dmem_pkg::STD_IO_BASE)
            read_val = gpr[st_r.eff_addr[4:0]];
        else if (in_io)
        begin
            unique case (st_r.eff_addr)
                dmem_pkg::EE_CTRL_ADDR:
                    read_val = {2'h0, pst_r.op, 1'b0, (st_r.arm_cnt != 3'h0), pst_r.busy,
                        1'b0};
                dmem_pkg::EE_DATA_ADDR: read_val = st_r.ee_data;
                dmem_pkg::EE_ADDRL_ADDR: read_val = st_r.ee_addr[7:0];
                dmem_pkg::EE_ADDRH_ADDR: read_val = {4'h0, st_r.ee_addr[11:8]};
                default: read_val = io_rdata_i;
            endcase
        end
        else if (st_r.eff_addr < dmem_pkg::SRAM_END)
            read_val = sram[sram_idx];
    end

    // Access sequencer
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata_valid = 1'b0;
        ptr_we = 1'b0;
        ptr_new = base_ptr;
        ctrl_wr = 1'b0;
        rd_start = 1'b0;
        wr_start = 1'b0;
        if (st_r.arm_cnt != 3'h0)
            st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
        unique case (st_r.state)
            dmem_pkg::ST_IDLE:
            begin
                if (req_i)
                begin
                    st_nxt.state = dmem_pkg::ST_EXEC;
                    st_nxt.kind = req_kind_i;
                    st_nxt.wdata = wdata_i;
                    st_nxt.sel = ptr_sel_i;
                    if (req_kind_i == dmem_pkg::ACC_IO_IN || req_kind_i == dmem_pkg::ACC_IO_OUT)
                        st_nxt.eff_addr = {10'h000, io_addr_i} + dmem_pkg::IO_DATA_OFFSET;
                    else
                    begin
                        unique case (addr_mode_i)
                            dmem_pkg::AM_INDIRECT: st_nxt.eff_addr = base_ptr;
                            dmem_pkg::AM_DISP:
                                st_nxt.eff_addr = base_ptr + {10'h000, disp_i};
                            dmem_pkg::AM_PREDEC:
                            begin
                                st_nxt.eff_addr = base_ptr - 16'h0001;
                                ptr_we = 1'b1;
                                ptr_new = base_ptr - 16'h0001;
                            end
                            dmem_pkg::AM_POSTINC:
                            begin
                                st_nxt.eff_addr = base_ptr;
                                ptr_we = 1'b1;
                                ptr_new = base_ptr + 16'h0001;
                            end
                            default: st_nxt.eff_addr = addr_i;
                        endcase
                    end
                end
            end
            dmem_pkg::ST_EXEC:
            begin
                st_nxt.state = dmem_pkg::ST_IDLE;
                if (!is_wr)
                begin
                    st_nxt.rdata = read_val;
                    st_nxt.rdata_valid = 1'b1;
                end
                else
                begin
                    unique case (st_r.eff_addr)
                        dmem_pkg::EE_DATA_ADDR: st_nxt.ee_data = st_r.wdata;
                        dmem_pkg::EE_ADDRL_ADDR: st_nxt.ee_addr[7:0] = st_r.wdata;
                        dmem_pkg::EE_ADDRH_ADDR: st_nxt.ee_addr[11:8] = st_r.wdata[3:0];
                        dmem_pkg::EE_CTRL_ADDR:
                        begin
                            ctrl_wr = 1'b1;
                            if (st_r.wdata[dmem_pkg::CTL_ARM_BIT])
                                st_nxt.arm_cnt = dmem_pkg::ARM_WINDOW_CYC;
                            if (st_r.wdata[dmem_pkg::CTL_STROBE_BIT] && st_r.arm_cnt != 3'h0 &&
                                !pst_r.busy && wr_op != dmem_pkg::OP_RESERVED)
                            begin
                                wr_start = 1'b1;
                                st_nxt.state = dmem_pkg::ST_STALL;
                                st_nxt.stall_cnt = dmem_pkg::WRITE_STALL_CYC;
                            end
                            else if (st_r.wdata[dmem_pkg::CTL_READ_BIT] && !pst_r.busy)
                            begin
                                rd_start = 1'b1;
                                st_nxt.ee_data = eeprom[st_r.ee_addr[10:0]];
                                st_nxt.state = dmem_pkg::ST_STALL;
                                st_nxt.stall_cnt = dmem_pkg::READ_STALL_CYC;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            dmem_pkg::ST_STALL:
            begin
                st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
                if (st_r.stall_cnt == 3'h1)
                    st_nxt.state = dmem_pkg::ST_IDLE;
            end
            default: st_nxt.state = dmem_pkg::ST_IDLE;
        endcase
        st_nxt.instr = flash[pc_i];
        st_nxt.boot = pc_boot;
        st_nxt.prog_refused = prog_we_i && !prog_ok;
    end

    // Boot section writable only from boot code
    assign pc_boot = (pc_i >= dmem_pkg::BOOT_START_WORD);
    assign prog_ok = prog_we_i && ((prog_waddr_i < dmem_pkg::BOOT_START_WORD) || pc_boot);

    // Self-timed write engine, cleared only by power-on reset except op, which system reset returns to erase/write when idle
    always_comb
    begin
        pst_nxt = pst_r;
        ee_commit = 1'b0;
        if (pst_r.busy)
        begin
            pst_nxt.timer = pst_r.timer - 19'h00001;
            if (pst_r.timer == 19'h00001)
            begin
                pst_nxt.busy = 1'b0;
                ee_commit = 1'b1;
            end
        end
        else if (wr_start)
        begin
            pst_nxt.busy = 1'b1;
            pst_nxt.op = wr_op;
            pst_nxt.addr = st_r.ee_addr[10:0];
            pst_nxt.data = st_r.ee_data;
            if (wr_op == dmem_pkg::OP_ERASE_WRITE)
                pst_nxt.timer = ERASE_WRITE_CYC[dmem_pkg::TIMER_W-1:0];
            else
                pst_nxt.timer = SINGLE_OP_CYC[dmem_pkg::TIMER_W-1:0];
        end
        else if (ctrl_wr)
            pst_nxt.op = wr_op;
        else if (!nrst_i)
            pst_nxt.op = dmem_pkg::OP_ERASE_WRITE;
    end

    always_comb
    begin
        unique case (pst_r.op)
            dmem_pkg::OP_ERASE_ONLY: ee_val = dmem_pkg::EE_ERASED;
            dmem_pkg::OP_WRITE_ONLY: ee_val = eeprom[pst_r.addr] & pst_r.data;
            default: ee_val = pst_r.data;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st_r <= ACC_RST;
        else if (clk_en_i)
            st_r <= st_nxt;
    end

    always_ff @(posedge core_clk_i or negedge pwr_on_nrst_i)
    begin
        if (!pwr_on_nrst_i)
            pst_r <= PST_RST;
        else if (clk_en_i)
            pst_r <= pst_nxt;
    end

    // Memory arrays
    always_ff @(posedge core_clk_i)
    begin
        if (clk_en_i)
        begin
            if (ptr_we && nrst_i)
            begin
                gpr[base_lo] <= ptr_new[7:0];
                gpr[base_lo + 5'h1] <= ptr_new[15:8];
            end
            if (gpr_we)
                gpr[st_r.eff_addr[4:0]] <= st_r.wdata;
            if (sram_we)
                sram[sram_idx] <= st_r.wdata;
            if (ee_commit)
                eeprom[pst_r.addr] <= ee_val;
            if (prog_ok)
                flash[prog_waddr_i] <= prog_wdata_i;
        end
    end

    assign ready_o = (st_r.state == dmem_pkg::ST_IDLE);
    assign cpu_wait_o = (st_r.state == dmem_pkg::ST_STALL);
    assign rdata_o = st_r.rdata;
    assign rdata_valid_o = st_r.rdata_valid;
    assign io_addr_o = st_r.eff_addr[7:0];
    assign io_wdata_o = st_r.wdata;
    assign io_we_o = (st_r.state == dmem_pkg::ST_EXEC) && is_wr && in_io && !is_ee_reg;
    assign io_re_o = (st_r.state == dmem_pkg::ST_EXEC) && !is_wr && in_io && !is_ee_reg;
    assign ee_busy_o = pst_r.busy;
    assign instr_o = st_r.instr;
    assign boot_section_o = st_r.boot;
    assign prog_refused_o = st_r.prog_refused;

    sequence s_wait_n4;
        cpu_wait_o [*4] ##1 !cpu_wait_o;
    endsequence
    sequence s_wait_n2;
        cpu_wait_o [*2] ##1 !cpu_wait_o;
    endsequence

    chk_read_stall_len: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        rd_start |=> s_wait_n4) else $error("EEPROM read stall not four cycles");
    chk_write_stall_len: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        wr_start |=> s_wait_n2) else $error("EEPROM write stall not two cycles");
    chk_load_two_cycles: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        (ready_o && req_i && (req_kind_i == dmem_pkg::ACC_LOAD)) |=> ##1 rdata_valid_o)
        else $error("Load did not complete in two cycles");
    chk_arm_guard: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr_start |-> (st_r.arm_cnt != 3'h0) && !pst_r.busy)
        else $error("Write started without arm");
    chk_arm_window: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        (st_r.arm_cnt == 3'h4) && !(ctrl_wr && st_r.wdata[dmem_pkg::CTL_ARM_BIT]) |=>
        (st_r.arm_cnt == 3'h3) ##1 (st_r.arm_cnt == 3'h2) ##1 (st_r.arm_cnt == 3'h1)
        ##1 (st_r.arm_cnt == 3'h0) || (st_r.arm_cnt == 3'h4))
        else $error("Arm window length wrong");
    chk_busy_clear: assert property (@(posedge core_clk_i) disable iff (!pwr_on_nrst_i || !clk_en_i)
        (pst_r.busy && pst_r.timer == 19'h00001) |=> !pst_r.busy && !ee_busy_o)
        else $error("Strobe not cleared at end of write");
    chk_reset_keeps: assert property (@(posedge core_clk_i) disable iff (!pwr_on_nrst_i || !clk_en_i)
        (!nrst_i && pst_r.busy && pst_r.timer > 19'h00001) |=> pst_r.busy)
        else $error("System reset aborted EEPROM write");
    chk_postinc_ptr: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        (ready_o && req_i && addr_mode_i == dmem_pkg::AM_POSTINC &&
        (req_kind_i == dmem_pkg::ACC_LOAD || req_kind_i == dmem_pkg::ACC_STORE))
        |=> lat_ptr == st_r.eff_addr + 16'h0001) else $error("Post-increment wrong");
    chk_disp_addr: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        (ready_o && req_i && req_kind_i == dmem_pkg::ACC_LOAD && addr_mode_i == dmem_pkg::AM_DISP)
        |=> st_r.eff_addr == $past(base_ptr) + {10'h000, $past(disp_i)})
        else $error("Displacement address wrong");
    chk_io_offset: assert property (@(posedge core_clk_i) disable iff (!nrst_i || !clk_en_i)
        (ready_o && req_i && req_kind_i == dmem_pkg::ACC_IO_IN) |=>
        (st_r.eff_addr == {10'h000, $past(io_addr_i)} + 16'h0020) &&
        (st_r.eff_addr < dmem_pkg::EXT_IO_BASE)) else $error("Short IO address wrong");
    chk_erase_time: assert property (@(posedge core_clk_i) disable iff (!pwr_on_nrst_i || !clk_en_i)
        (wr_start && wr_op == dmem_pkg::OP_ERASE_ONLY) |=>
        pst_r.timer == SINGLE_OP_CYC[dmem_pkg::TIMER_W-1:0]) else $error("Erase time wrong");
endmodule // data_memory_eeprom_access

/* File: pkg/dmem_pkg.sv */
/*
 Constants, field positions and types shared by the data-memory and EEPROM access block.
 Assumes a 100 MHz core clock and the documented data-space layout.
*/
package dmem_pkg;
    // Clock and programming times
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_ERASE_WRITE_NS = 3400000;
    localparam int unsigned T_SINGLE_OP_NS = 1800000;
    localparam int unsigned ERASE_WRITE_CYC = T_ERASE_WRITE_NS / CLK_PERIOD_NS;
    localparam int unsigned SINGLE_OP_CYC = T_SINGLE_OP_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 19;

    // Data-space layout
    localparam logic [15:0] STD_IO_BASE = 16'h0020;
    localparam logic [15:0] EXT_IO_BASE = 16'h0060;
    localparam logic [15:0] SRAM_BASE = 16'h0100;
    localparam logic [15:0] SRAM_END = 16'h1100;
    localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
    localparam int SRAM_WORDS = 4096;
    localparam int EE_WORDS = 2048;
    localparam int FLASH_WORDS = 65536;

    // EEPROM access registers, as data-space addresses
    localparam logic [15:0] EE_CTRL_ADDR = 16'h003f;
    localparam logic [15:0] EE_DATA_ADDR = 16'h0040;
    localparam logic [15:0] EE_ADDRL_ADDR = 16'h0041;
    localparam logic [15:0] EE_ADDRH_ADDR = 16'h0042;

    // Control register fields
    localparam int CTL_READ_BIT = 0;
    localparam int CTL_STROBE_BIT = 1;
    localparam int CTL_ARM_BIT = 2;
    localparam int CTL_OPSEL_LSB = 4;

    // Cycle counts
    localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
    localparam logic [2:0] READ_STALL_CYC = 3'h4;
    localparam logic [2:0] WRITE_STALL_CYC = 3'h2;

    // Pointer low-byte registers
    localparam logic [4:0] X_LO_REG = 5'h1a;
    localparam logic [4:0] Y_LO_REG = 5'h1c;
    localparam logic [4:0] Z_LO_REG = 5'h1e;

    // Program memory and EEPROM erased value
    localparam logic [15:0] BOOT_START_WORD = 16'hf000;
    localparam logic [7:0] EE_ERASED = 8'hff;

    typedef enum logic [1:0] {
        OP_ERASE_WRITE = 2'h0,
        OP_ERASE_ONLY = 2'h1,
        OP_WRITE_ONLY = 2'h2,
        OP_RESERVED = 2'h3
    } ee_op_e;

    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0,
        AM_INDIRECT = 3'h1,
        AM_DISP = 3'h2,
        AM_PREDEC = 3'h3,
        AM_POSTINC = 3'h4
    } addr_mode_e;

    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } ptr_sel_e;

    typedef enum logic [1:0] {
        ACC_LOAD = 2'h0,
        ACC_STORE = 2'h1,
        ACC_IO_IN = 2'h2,
        ACC_IO_OUT = 2'h3
    } acc_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_STALL = 2'h3
    } acc_state_e;
endpackage
